/* logic/lres_pkg.sv */
// constants, register map and delay tables for the auxiliary ldo rail enable sequencer
package lres_pkg;

    // register offsets, byte addresses on the register port
    localparam logic [7:0] OFS_PG_MASK      = 8'h1c;
    localparam logic [7:0] OFS_SOURCE_SEL   = 8'h1d;
    localparam logic [7:0] OFS_EDGE_DELAYS  = 8'h1e;
    localparam logic [7:0] OFS_STATUS       = 8'hf0;
    localparam logic [7:0] OFS_PIN_STATE    = 8'hf1;
    localparam logic [7:0] OFS_PG_STATE     = 8'hf2;

    // values after reset
    localparam logic [7:0] RST_PG_MASK      = 8'h00;
    localparam logic [7:0] RST_SOURCE_SEL   = 8'h00;
    localparam logic [7:0] RST_EDGE_DELAYS  = 8'h00;

    // field positions in the source select register
    localparam int POS_SWITCH_GROUP_B_FIRST_MASK    = 0;
    localparam int POS_SWB2_MASK    = 1;
    localparam int POS_SRC_LO       = 2;
    localparam int SOURCE_SEL_USED  = 5;

    // field positions in the edge delay register
    localparam int POS_RISE_LO      = 0;
    localparam int POS_FALL_LO      = 3;
    localparam int POS_OFF_LO       = 6;

    // status register bit positions
    localparam int POS_ST_RAW       = 0;
    localparam int POS_ST_EN        = 1;
    localparam int POS_ST_PEND      = 2;
    localparam int POS_ST_OFF       = 3;

    // sizes
    localparam int N_CTRL           = 6;
    localparam int N_RAIL_PG        = 8;
    localparam int N_SWB_PG         = 2;
    localparam int N_SYNC           = N_CTRL + N_RAIL_PG + N_SWB_PG;
    localparam int MS_W             = 7;
    localparam int CYC_W            = 17;

    // timing: one millisecond at the 8 ns clock
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int MS_IN_PS         = 1000000000;
    localparam int CYC_PER_MS       = MS_IN_PS / CLK_PERIOD_PS;

    // enable source codes
    typedef enum logic [2:0] {
        SRC_CONTROL_INPUT_1      = 3'h0,
        SRC_CTL2      = 3'h1,
        SRC_CTL5      = 3'h2,
        SRC_CTL4      = 3'h3,
        SRC_CONTROL_INPUT_3      = 3'h4,
        SRC_CONTROL_INPUT_3_CTL4 = 3'h5,
        SRC_CONTROL_INPUT_6      = 3'h6,
        SRC_ALWAYS_ON = 3'h7
    } lres_src_e;

    // edge delay in ms per code: none, 2, 4, 8, 16, 24, 32, 64
    localparam logic [MS_W-1:0] EDGE_MS [8] = '{
        7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40
    };

    // first ldo off time in ms per code: 1, 5, 10, 100
    localparam logic [MS_W-1:0] OFF_MS [4] = '{7'h01, 7'h05, 7'h0a, 7'h64};

endpackage

/* logic/lres_edge_delay.sv */
// delays each edge of a level by a programmable number of milliseconds
`timescale 1ns/1ps
module lres_edge_delay
    import lres_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    input  wire logic            level_i,
    input  wire logic [MS_W-1:0] rise_ms_i,
    input  wire logic [MS_W-1:0] fall_ms_i,
    output logic                 level_o,
    output logic                 pending_o
);

    logic             prev_q;
    logic             pend_q;
    logic [CYC_W-1:0] cyc_q;
    logic [MS_W-1:0]  ms_q;
    logic             ms_tick;
    logic             restart;
    logic [MS_W-1:0]  target;

    // a change of the input restarts timing, dropping any edge still waiting
    assign restart = (level_i != prev_q);
    assign target  = level_i ? rise_ms_i : fall_ms_i;
    assign ms_tick = (cyc_q == CYC_W'(CYCLES_PER_MS - 1));

    // last seen input, for change detection
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prev_q <= 1'b0;
        else
            prev_q <= level_i;
    end

    // millisecond divider, restarted with each edge so the delay is not short by a phase
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cyc_q <= '0;
            ms_q  <= '0;
        end
        else if (restart || !pend_q)
        begin
            cyc_q <= '0; // [R12]
            ms_q  <= '0;
        end
        else if (ms_tick)
        begin
            cyc_q <= '0;
            ms_q  <= ms_q + 7'h01;
        end
        else
        begin
            cyc_q <= cyc_q + 17'h00001;
        end
    end

    // pending edge and delayed output; target is sampled live so a rewrite takes effect
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pend_q  <= 1'b0;
            level_o <= 1'b0;
        end
        else if (restart)
        begin
            pend_q <= (level_i != level_o); // [R12]
        end
        else if (pend_q && (ms_q >= target))
        begin
            level_o <= level_i; // [R7] [R8] [R9]
            pend_q  <= 1'b0;
        end
    end

    assign pending_o = pend_q;

endmodule

/* logic/lres_ldo_rail_enable.sv */
// enable qualification for the second auxiliary ldo rail, with its register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

// Function
// [R1] Mask register bit 7 masks aux ldo three, bit 6 the first load switch, bits 5..0 bucks six..one.
// [R2] A clear mask bit keeps that rail's power good inside the enable condition.
// [R3] Source select bit 0 masks switch group b first, bit 1 switch b second with ldo one.
// [R4] Source codes 000..011 pick control inputs 1, 2, 5 and 4.
// [R5] Source codes 100, 101 and 110 pick input 3, inputs 3 and 4 together, and input 6.
// [R6] Source code 111 feeds a constant one so no pin is needed.
// [R7] Delay bits 2:0 delay the rising enable edge by 0, 2, 4, 8, 16, 24, 32 or 64 ms.
// [R8] Delay bits 5:3 delay the falling enable edge with the same table.
// [R9] Each edge delay may be off its nominal value by up to ten percent.
// [R10] Delay bits 7:6 set the first ldo off time at shutdown to 1, 5, 10 or 100 ms.
// [R11] The raw enable is the selected source ANDed with every unmasked power good.
// [R12] A new change of the raw enable abandons a waiting edge and restarts its timing.
module lres_ldo_rail_enable
    import lres_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic [N_CTRL-1:0]    control_input_i,
    input  wire logic [N_RAIL_PG-1:0] rail_power_good_i,
    input  wire logic [N_SWB_PG-1:0]  switch_b_power_good_i,
    output logic                      aux_ldo_two_en_o,
    output logic                      first_ldo_off_o
);

    // software registers
    logic [7:0]              pg_mask_q;
    logic [7:0]              source_sel_q;
    logic [7:0]              edge_delays_q;

    // pin synchronisers
    logic [N_SYNC-1:0]       pins_in;
    logic [N_SYNC-1:0]       sync1_q;
    logic [N_SYNC-1:0]       sync2_q;
    logic [N_SYNC-1:0]       sync3_q;
    logic [N_SYNC-1:0]       pins_q;

    // filtered pin views
    logic [N_CTRL-1:0]       ctl;
    logic [N_RAIL_PG-1:0]    rail_pg;
    logic [N_SWB_PG-1:0]     swb_pg;

    // enable path
    lres_src_e               src_sel;
    logic                    src_level;
    logic                    pg_ok;
    logic                    raw_en_q;
    logic                    delayed_en;
    logic                    delay_pending;
    logic [MS_W-1:0]         rise_ms;
    logic [MS_W-1:0]         fall_ms;
    logic [MS_W-1:0]         off_ms;

    // first ldo off timer
    logic                    en_prev_q;
    logic [CYC_W-1:0]        off_cyc_q;
    logic [MS_W-1:0]         off_cnt_q;
    logic                    off_ms_tick;

    // read path
    logic [7:0]              rd_mux;
    logic [7:0]              status;

    assign pins_in = {switch_b_power_good_i, rail_power_good_i, control_input_i};

    // three-stage capture of every asynchronous pin
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end
        else
        begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a pin change is accepted only when the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < N_SYNC; gi++)
        begin : g_pin
            always_ff @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    pins_q[gi] <= 1'b0;
                else if (sync2_q[gi] == sync3_q[gi])
                    pins_q[gi] <= sync3_q[gi];
            end
        end
    endgenerate

    assign ctl     = pins_q[N_CTRL-1:0];
    assign rail_pg = pins_q[N_CTRL +: N_RAIL_PG];
    assign swb_pg  = pins_q[N_CTRL+N_RAIL_PG +: N_SWB_PG];

    // power good mask register; a set bit takes that rail out of the enable condition
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pg_mask_q <= RST_PG_MASK;
        else if (wr_i && (addr_i == OFS_PG_MASK))
            pg_mask_q <= wdata_i; // [R1]
    end

    // source select register; reserved bits 7:5 are kept as written
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            source_sel_q <= RST_SOURCE_SEL;
        else if (wr_i && (addr_i == OFS_SOURCE_SEL))
            source_sel_q <= wdata_i; // [R3]
    end

    // edge delay and off time register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            edge_delays_q <= RST_EDGE_DELAYS;
        else if (wr_i && (addr_i == OFS_EDGE_DELAYS))
            edge_delays_q <= wdata_i;
    end

    assign src_sel = lres_src_e'(source_sel_q[POS_SRC_LO +: 3]);

    // enable source multiplexer
    always_comb
    begin
        case (src_sel)
            SRC_CONTROL_INPUT_1:      src_level = ctl[0]; // [R4]
            SRC_CTL2:      src_level = ctl[1]; // [R4]
            SRC_CTL5:      src_level = ctl[4]; // [R4]
            SRC_CTL4:      src_level = ctl[3]; // [R4]
            SRC_CONTROL_INPUT_3:      src_level = ctl[2]; // [R5]
            SRC_CONTROL_INPUT_3_CTL4: src_level = ctl[2] & ctl[3]; // [R5]
            SRC_CONTROL_INPUT_6:      src_level = ctl[5]; // [R5]
            SRC_ALWAYS_ON: src_level = 1'b1; // [R6]
            default:       src_level = 1'b0;
        endcase
    end

    // each power good passes when present or masked
    assign pg_ok = &(rail_pg | pg_mask_q) // [R1] [R2]
        & (swb_pg[0] | source_sel_q[POS_SWITCH_GROUP_B_FIRST_MASK]) // [R3]
        & (swb_pg[1] | source_sel_q[POS_SWB2_MASK]); // [R3]

    // registered raw enable, so the delay stage sees a glitch-free level
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            raw_en_q <= 1'b0;
        else
            raw_en_q <= src_level & pg_ok; // [R11]
    end

    assign rise_ms = EDGE_MS[edge_delays_q[POS_RISE_LO +: 3]]; // [R7]
    assign fall_ms = EDGE_MS[edge_delays_q[POS_FALL_LO +: 3]]; // [R8]
    assign off_ms  = OFF_MS[edge_delays_q[POS_OFF_LO +: 2]]; // [R10]

    // edge delays act on the combined enable
    lres_edge_delay #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_edge_delay (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .level_i       (raw_en_q), // [R11]
        .rise_ms_i     (rise_ms),
        .fall_ms_i     (fall_ms),
        .level_o       (delayed_en),
        .pending_o     (delay_pending)
    );

    // rail enable output, one flop after the delay stage
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            aux_ldo_two_en_o <= 1'b0;
        else
            aux_ldo_two_en_o <= delayed_en;
    end

    assign off_ms_tick = (off_cyc_q == CYC_W'(CYCLES_PER_MS - 1));

    // shutdown edge detector for the off timer
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            en_prev_q <= 1'b0;
        else
            en_prev_q <= delayed_en;
    end

    // first ldo is held off for the programmed time after the rail shuts down;
    // the timer runs to the end even if the rail is enabled again meanwhile
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            first_ldo_off_o <= 1'b0;
            off_cyc_q       <= '0;
            off_cnt_q       <= '0;
        end
        else if (en_prev_q && !delayed_en)
        begin
            first_ldo_off_o <= 1'b1; // [R10]
            off_cyc_q       <= '0;
            off_cnt_q       <= '0;
        end
        else if (first_ldo_off_o)
        begin
            if (off_ms_tick)
            begin
                off_cyc_q <= '0;
                off_cnt_q <= off_cnt_q + 7'h01;
                if ((off_cnt_q + 7'h01) >= off_ms)
                    first_ldo_off_o <= 1'b0; // [R10]
            end
            else
            begin
                off_cyc_q <= off_cyc_q + 17'h00001;
            end
        end
    end

    assign status = {4'h0, first_ldo_off_o, delay_pending, aux_ldo_two_en_o, raw_en_q};

    // read decode; unmapped addresses read zero
    always_comb
    begin
        case (addr_i)
            OFS_PG_MASK:     rd_mux = pg_mask_q;
            OFS_SOURCE_SEL:  rd_mux = source_sel_q;
            OFS_EDGE_DELAYS: rd_mux = edge_delays_q;
            OFS_STATUS:      rd_mux = status;
            OFS_PIN_STATE:   rd_mux = {2'h0, ctl};
            OFS_PG_STATE:    rd_mux = rail_pg;
            default:         rd_mux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rd_mux;
        else
            rdata_o <= 8'h00;
    end

endmodule

/* verification/lres_checker.sv */
// port assertions for the auxiliary ldo rail enable sequencer
`timescale 1ns/1ps
module lres_checker
    import lres_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
    input wire logic                 clk_i,
    input wire logic                 rst_b_i,
    input wire logic [7:0]           addr_i,
    input wire logic [7:0]           wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire logic [N_CTRL-1:0]    control_input_i,
    input wire logic [N_RAIL_PG-1:0] rail_power_good_i,
    input wire logic [N_SWB_PG-1:0]  switch_b_power_good_i,
    input wire logic                 aux_ldo_two_en_o,
    input wire logic                 first_ldo_off_o
);
    localparam int PIN [8] = '{0, 1, 4, 3, 2, 2, 5, 0};
    logic [7:0]  msk_q, src_q, dly_q;
    logic [10:0] run_q, offc_q;
    logic        raw_w, raw_q;
    int          rise_w, fall_w, off_w;
    // shadow copies of the control registers, taken from the write strobes
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i) {msk_q, src_q, dly_q} <= 24'h000000;
        else if (wr_i && addr_i == OFS_PG_MASK) msk_q <= wdata_i;
        else if (wr_i && addr_i == OFS_SOURCE_SEL) src_q <= wdata_i;
        else if (wr_i && addr_i == OFS_EDGE_DELAYS) dly_q <= wdata_i;
    // expected raw enable straight from the pins; it leads the design by the pin filter
    assign raw_w = ((src_q[4:2] == 3'h7) | (control_input_i[PIN[src_q[4:2]]]
                   & ((src_q[4:2] != 3'h5) | control_input_i[3])))
                   & (&(rail_power_good_i | msk_q)) & (&(switch_b_power_good_i | src_q[1:0]));
    assign rise_w = int'(EDGE_MS[dly_q[2:0]]) * CYCLES_PER_MS;
    assign fall_w = int'(EDGE_MS[dly_q[5:3]]) * CYCLES_PER_MS;
    assign off_w = int'(OFF_MS[dly_q[7:6]]) * CYCLES_PER_MS;
    // quiet time of the raw enable; a write restarts it since delays are read live
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i) run_q <= 11'h000;
        else if (raw_w != raw_q || wr_i) run_q <= 11'h000;
        else if (run_q != 11'h7ff) run_q <= run_q + 11'h001;
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i) raw_q <= 1'b0;
        else raw_q <= raw_w;
    // length of the current off window
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i) offc_q <= 11'h000;
        else if (first_ldo_off_o) offc_q <= offc_q + 11'h001;
        else offc_q <= 11'h000;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_wr_rd(a);
        wr_i && addr_i == a ##2 rd_i && addr_i == a;
    endsequence
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
    property p_mask_rb;
        s_wr_rd(OFS_PG_MASK) |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask read back");
    property p_dly_rb;
        s_wr_rd(OFS_EDGE_DELAYS) |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_dly_rb: assert property (p_dly_rb) else $error("delay read back");
    property p_en_follow;
        raw_w && run_q == 11'(rise_w * 11 / 10 + 16) |-> aux_ldo_two_en_o;
    endproperty
    a_en_follow: assert property (p_en_follow) else $error("enable late");
    property p_fall_follow;
        !raw_w && run_q == 11'(fall_w * 11 / 10 + 16) |-> !aux_ldo_two_en_o;
    endproperty
    a_fall_follow: assert property (p_fall_follow) else $error("disable late");
    property p_rise_early;
        $rose(aux_ldo_two_en_o) |-> int'(run_q) >= rise_w * 9 / 10;
    endproperty
    a_rise_early: assert property (p_rise_early) else $error("enable early");
    property p_off_start;
        $fell(aux_ldo_two_en_o) |-> ##[1:3] first_ldo_off_o;
    endproperty
    a_off_start: assert property (p_off_start) else $error("off window missing");
    property p_off_len;
        $fell(first_ldo_off_o) |-> int'(offc_q) inside {[off_w * 9 / 10 : off_w * 11 / 10 + 2]};
    endproperty
    a_off_len: assert property (p_off_len) else $error("off window length");
endmodule

bind lres_ldo_rail_enable lres_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_lres_checker (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .control_input_i(control_input_i),
    .rail_power_good_i(rail_power_good_i), .switch_b_power_good_i(switch_b_power_good_i),
    .aux_ldo_two_en_o(aux_ldo_two_en_o), .first_ldo_off_o(first_ldo_off_o));

/* verification/lres_pin_model.sv */
// system logic that drives the control pins and the power good lines
`timescale 1ns/1ps
module lres_pin_model
    import lres_pkg::*;
(
    input  wire logic                 clk_i,
    output logic      [N_CTRL-1:0]    control_input_o,
    output logic      [N_RAIL_PG-1:0] rail_power_good_o,
    output logic      [N_SWB_PG-1:0]  switch_b_power_good_o
);
    // every line idles low until asked to move
    initial
    begin
        control_input_o = '0;
        rail_power_good_o = '0;
        switch_b_power_good_o = '0;
    end
    // lag lets the far side answer late; all lines move at one edge so no glitch shows
    task automatic put(input logic [N_CTRL-1:0] c, input logic [N_RAIL_PG-1:0] p,
                       input logic [N_SWB_PG-1:0] s, input int lag);
        repeat (lag + 1) @(posedge clk_i);
        control_input_o <= c;
        rail_power_good_o <= p;
        switch_b_power_good_o <= s;
    endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the auxiliary ldo rail enable sequencer
`timescale 1ns/1ps
module tb_top;
    import lres_pkg::*;
    localparam int CPM = 10;
    logic                 clk_i, rst_b_i, wr_i, rd_i, aux_ldo_two_en_o, first_ldo_off_o;
    logic [7:0]           addr_i, wdata_i, rdata_o;
    logic [N_CTRL-1:0]    ctl_w;
    logic [N_RAIL_PG-1:0] pg_w;
    logic [N_SWB_PG-1:0]  swb_w;
    logic [31:0]          seed = 32'h3fd4;
    int                   fail_count, num_checks, n, c, p, s;
    int                   reg_m [3];
    int                   ms_q [$] = '{0, 2, 4, 8, 16, 24, 32, 64};
    int                   off_q [$] = '{1, 5, 10, 100};

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    lres_ldo_rail_enable #(.CYCLES_PER_MS(CPM)) u_lres_ldo_rail_enable (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .control_input_i(ctl_w), .rail_power_good_i(pg_w),
        .switch_b_power_good_i(swb_w), .aux_ldo_two_en_o(aux_ldo_two_en_o),
        .first_ldo_off_o(first_ldo_off_o));
    lres_pin_model u_lres_pin_model (.clk_i(clk_i), .control_input_o(ctl_w),
        .rail_power_good_o(pg_w), .switch_b_power_good_o(swb_w));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // model of the raw enable: chosen pin and every power good not masked
    function automatic bit raw_m(int ci, int pi, int si);
        int code = (reg_m[1] >> 2) & 7;
        int pin [8] = '{0, 1, 4, 3, 2, 2, 5, 0};
        bit sel = code == 7 || ((ci >> pin[code] & 1) && (code != 5 || (ci >> 3 & 1)));
        return sel && ((pi | reg_m[0]) & 255) == 255 && ((si | reg_m[1]) & 3) == 3;
    endfunction
    // nominal delay with the tolerance, plus margin for the pin filter
    function automatic bit inr(int cyc, int ms);
        return cyc >= ms * CPM * 9 / 10 && cyc <= ms * CPM * 11 / 10 + 16;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a >= 8'h1c && a <= 8'h1e) reg_m[a - 8'h1c] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask
    // bounded wait for an output level, counting the cycles it took
    task automatic wait_for(input bit off, input logic v, output int cyc);
        cyc = 0;
        while (((off ? first_ldo_off_o : aux_ldo_two_en_o) !== v) && cyc < 3000)
        begin
            @(posedge clk_i);
            cyc++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        reg_m = '{0, 0, 0};
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // reset values, random read back, and an unmapped hole that reads zero
        for (int i = 0; i < 3; i++)
        begin
            rd(8'h1c + 8'(i), 8'h00);
            n = xs();
            wr(8'h1c + 8'(i), 8'(n));
            rd(8'h1c + 8'(i), 8'(n));
        end
        rd(8'h40, 8'h00);
        $display("register test done");
        // each source code in turn, random masks and pins with no delay; the far side answers with a lag
        wr(8'h1e, 8'h00);
        for (int i = 0; i < 48; i++)
        begin
            wr(8'h1c, 8'(xs() | xs()));
            wr(8'h1d, {3'h0, 3'(i), 2'(xs())});
            c = xs();
            p = xs() | xs() | xs();
            s = xs() | xs();
            u_lres_pin_model.put(6'(c), 8'(p), 2'(s), i % 4);
            repeat (24) @(posedge clk_i);
            check(aux_ldo_two_en_o, raw_m(c, p, s));
        end
        $display("enable logic test done");
        // every rise and fall code timed, with rise and fall codes differing
        u_lres_pin_model.put(6'h00, 8'h00, 2'h0, 0);
        wr(8'h1c, 8'hff);
        wr(8'h1d, 8'h03);
        repeat (24) @(posedge clk_i);
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h1e, {2'h0, 3'(k), 3'(7 - k)});
            u_lres_pin_model.put(6'h01, 8'h00, 2'h0, 0);
            wait_for(0, 1'b1, n);
            check(inr(n, ms_q[7 - k]), 1);
            u_lres_pin_model.put(6'h00, 8'h00, 2'h0, 0);
            wait_for(0, 1'b0, n);
            check(inr(n, ms_q[k]), 1);
        end
        $display("edge delay test done");
        // a dip during a pending rise restarts the full delay
        wr(8'h1e, 8'h03);
        u_lres_pin_model.put(6'h01, 8'h00, 2'h0, 0);
        repeat (4 * CPM) @(posedge clk_i);
        u_lres_pin_model.put(6'h00, 8'h00, 2'h0, 0);
        repeat (CPM) @(posedge clk_i);
        u_lres_pin_model.put(6'h01, 8'h00, 2'h0, 0);
        wait_for(0, 1'b1, n);
        check(inr(n, 8), 1);
        // settled state: raw and delayed enable high, pin 1 seen, no power good present
        rd(8'hf0, 8'h03);
        rd(8'hf1, 8'h01);
        rd(8'hf2, 8'h00);
        $display("restart test done");
        // off window length for each code
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h1e, {2'(k), 6'h00});
            u_lres_pin_model.put(6'h01, 8'h00, 2'h0, 0);
            wait_for(0, 1'b1, n);
            u_lres_pin_model.put(6'h00, 8'h00, 2'h0, 0);
            wait_for(1, 1'b1, n);
            wait_for(1, 1'b0, n);
            check(inr(n, off_q[k]), 1);
        end
        $display("off time test done");
        end_sim();
    end

    // the run needs well under twenty thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end
endmodule
